// ==== hdl/pcb_pkg.sv ====
package pcb_pkg;

  // ****************************************************************
  // mode selector codes
  // ****************************************************************
  localparam logic [4:0] PCB_MODE_RESET      = 5'h1F;
  localparam logic [4:0] PCB_MODE_DIR_WR     = 5'h1F;
  localparam logic [4:0] PCB_MODE_PULL_WR    = 5'h1E;
  localparam logic [4:0] PCB_MODE_LVL_WR     = 5'h1D;
  localparam logic [4:0] PCB_MODE_ST_WR      = 5'h1C;
  localparam logic [4:0] PCB_MODE_WKEN_WR    = 5'h1B;
  localparam logic [4:0] PCB_MODE_WKED_WR    = 5'h1A;
  localparam logic [4:0] PCB_MODE_PEND_XCH   = 5'h19;
  localparam logic [4:0] PCB_MODE_CMP_XCH    = 5'h18;
  localparam logic [4:0] PCB_MODE_DIR_RD     = 5'h0F;
  localparam logic [4:0] PCB_MODE_PULL_RD    = 5'h0E;
  localparam logic [4:0] PCB_MODE_LVL_RD     = 5'h0D;
  localparam logic [4:0] PCB_MODE_ST_RD      = 5'h0C;
  localparam logic [4:0] PCB_MODE_WKEN_LO    = 5'h0B;
  localparam logic [4:0] PCB_MODE_WKED_LO    = 5'h0A;
  localparam logic [4:0] PCB_MODE_PEND_LO    = 5'h09;
  localparam logic [4:0] PCB_MODE_CMP_LO     = 5'h08;
  localparam int         PCB_MODE_WR_BIT     = 4;

  // ****************************************************************
  // ports, reset values, comparator fields
  // ****************************************************************
  localparam int         PCB_NPORT           = 5;
  localparam logic [2:0] PCB_PORT_A          = 3'h0;
  localparam logic [2:0] PCB_PORT_B          = 3'h1;
  localparam logic [7:0] PCB_REG_RESET       = 8'hFF;
  localparam int         PCB_CMP_DIS_BIT     = 7;
  localparam int         PCB_CMP_OE_N_BIT    = 6;
  localparam int         PCB_CMP_RES_BIT     = 0;
  localparam int         PCB_CMP_OUT_PIN     = 0;

  // one control move from the core
  typedef struct packed {
    logic       valid;
    logic [2:0] port;
    logic [7:0] wdata;
  } pcb_move_type;

  // per-port pin configuration
  typedef struct packed {
    logic [7:0] dir_in;
    logic [7:0] pull_dis;
    logic [7:0] ttl_sel;
    logic [7:0] schmitt_dis;
  } pcb_pincfg_type;

endpackage

// ==== hdl/pcb_port_cfg.sv ====
`timescale 1ns/1ns
module pcb_port_cfg
  import pcb_pkg::*;
#(
  parameter int NPORT = PCB_NPORT
) (
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  // mode selector access from the core
  input  wire logic                    mode_wr_i,
  input  wire logic [4:0]              mode_wdata_i,
  output logic      [4:0]              mode_o,
  // indirect control move from the core
  input  wire pcb_move_type            move_i,
  output logic      [7:0]              move_rdata_o,
  output logic                         move_rvalid_o,
  // pin side
  input  wire logic [NPORT*8-1:0]      pin_level_i,
  input  wire logic                    cmp_above_i,
  output pcb_pincfg_type [NPORT-1:0]   pincfg_o,
  output logic      [7:0]              cmp_pin_out_o,
  output logic      [7:0]              cmp_pin_oe_o,
  // wakeup and comparator status
  output logic      [7:0]              wake_pending_o,
  output logic                         wake_event_o,
  output logic                         cmp_enable_o
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (NPORT != PCB_NPORT) begin : g_bad_nport
    $error("pcb_port_cfg: NPORT must equal the five-port layout");
  end
  // field positions must fall inside the registers they name
  if (PCB_PORT_B >= NPORT) begin : g_bad_port_b
    $error("pcb_port_cfg: the wakeup port must be one of the ports");
  end
  if (PCB_MODE_WR_BIT > 4) begin : g_bad_wr_bit
    $error("pcb_port_cfg: the write bit must lie in the mode selector");
  end
  if ((PCB_CMP_DIS_BIT > 7) || (PCB_CMP_OE_N_BIT > 7)) begin : g_bad_cmp_bits
    $error("pcb_port_cfg: comparator control bits must lie in the byte");
  end
  if ((PCB_CMP_RES_BIT != 0) || (PCB_CMP_OUT_PIN > 7)) begin : g_bad_cmp_pin
    $error("pcb_port_cfg: comparator flag must be bit zero, its pin in port B");
  end

  // ****************************************************************
  // latency summary
  // ****************************************************************
  // mode write: new selector seen by a move in the next cycle
  // control move: answer and its valid pulse one cycle after the move
  // answer data is recomputed every cycle and reads zero without a move
  // config write: register one cycle, pad view one cycle later
  // pad view is registered so every pin setting leaves from a flop
  // wake enable and edge registers are write-only; moves answer zero
  // mode codes 08h to 0Bh on port B act as their 18h to 1Bh twins
  // wake edge: pin compared with its level one cycle earlier
  // pending bit and event pulse appear one cycle after the edge
  // a same-cycle edge beats a software clear of its pending bit
  // comparator flag: one cycle behind the analog input
  // comparator pin: one further cycle behind the flag
  // comparator enable leaves its own flop, no gate on the output
  // absent ports and undefined modes answer zero and change nothing
  // a write to the trigger register of port A is dropped
  // port A has no trigger, so its disable bits stay high

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [4:0]       mode_ff;
  logic [7:0]       dir_ff      [NPORT];
  logic [7:0]       pull_ff     [NPORT];
  logic [7:0]       lvl_ff      [NPORT];
  logic [7:0]       st_ff       [NPORT];
  logic [7:0]       wken_ff;
  logic [7:0]       wked_ff;
  logic [7:0]       pend_ff;
  logic [7:0]       cmp_ctl_ff;
  logic             cmp_res_ff;
  logic [7:0]       rdata_ff;
  logic             rvalid_ff;
  logic             wake_evt_ff;
  logic [7:0]       cmp_out_ff;
  logic [7:0]       cmp_oe_ff;
  logic             cmp_en_ff;
  pcb_pincfg_type [NPORT-1:0] pincfg_ff;
  logic [7:0]       wake_edges;
  logic [7:0]       nxt_pend;
  logic [7:0]       nxt_rdata;
  logic             is_wr;
  logic             port_ok;
  logic             on_b;
  logic             pend_xch;
  logic             cmp_xch;
  logic [7:0]       port_b_pins;

  assign is_wr       = mode_ff[PCB_MODE_WR_BIT];
  assign port_ok     = move_i.valid && (move_i.port < 3'(NPORT));
  assign on_b        = port_ok && (move_i.port == PCB_PORT_B);
  assign port_b_pins = pin_level_i[8*PCB_PORT_B +: 8];
  // both halves of the table exchange for the pending and comparator codes
  assign pend_xch    = on_b && ((mode_ff == PCB_MODE_PEND_XCH) ||
                                (mode_ff == PCB_MODE_PEND_LO));
  assign cmp_xch     = on_b && ((mode_ff == PCB_MODE_CMP_XCH) ||
                                (mode_ff == PCB_MODE_CMP_LO));

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // one flag per access kind
  logic             hit_dir_wr;
  logic             hit_pull_wr;
  logic             hit_lvl_wr;
  logic             hit_st_wr;
  logic             hit_wken;
  logic             hit_wked;

  // both table halves hit the write-only wake registers
  assign hit_dir_wr  = (mode_ff == PCB_MODE_DIR_WR);
  assign hit_pull_wr = (mode_ff == PCB_MODE_PULL_WR);
  assign hit_lvl_wr  = (mode_ff == PCB_MODE_LVL_WR);
  assign hit_st_wr   = (mode_ff == PCB_MODE_ST_WR);
  assign hit_wken    = (mode_ff == PCB_MODE_WKEN_WR) || (mode_ff == PCB_MODE_WKEN_LO);
  assign hit_wked    = (mode_ff == PCB_MODE_WKED_WR) || (mode_ff == PCB_MODE_WKED_LO);

  // ****************************************************************
  // mode selector
  // ****************************************************************
  // holds across any number of moves until rewritten
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_ff <= PCB_MODE_RESET;
    end else if (mode_wr_i) begin
      mode_ff <= mode_wdata_i;
    end
  end

  // ****************************************************************
  // per-port configuration registers
  // ****************************************************************
  // all registers come up at FFh: input, no pull-up, TTL, no Schmitt
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      logic sel;
      // this port addressed by a write move
      assign sel = port_ok && is_wr && (move_i.port == 3'(p));
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          dir_ff[p]  <= PCB_REG_RESET;
          pull_ff[p] <= PCB_REG_RESET;
          lvl_ff[p]  <= PCB_REG_RESET;
          st_ff[p]   <= PCB_REG_RESET;
        end else if (sel) begin
          if (hit_dir_wr) begin
            dir_ff[p] <= move_i.wdata;
          end
          if (hit_pull_wr) begin
            pull_ff[p] <= move_i.wdata;
          end
          if (hit_lvl_wr) begin
            lvl_ff[p] <= move_i.wdata;
          end
          // port A has no trigger, so its register stays at reset
          if (hit_st_wr && (p != 0)) begin
            st_ff[p] <= move_i.wdata;
          end
        end
      end
      // pin configuration seen by the pad logic
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          pincfg_ff[p] <= {4{PCB_REG_RESET}};
        end else begin
          pincfg_ff[p].dir_in      <= dir_ff[p];
          pincfg_ff[p].pull_dis    <= pull_ff[p];
          // level only matters while the trigger is off; port A forced off
          pincfg_ff[p].ttl_sel     <= lvl_ff[p];
          pincfg_ff[p].schmitt_dis <= (p == 0) ? PCB_REG_RESET : st_ff[p];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // wakeup enable and edge select
  // ****************************************************************
  // write-only; either half of the table writes these
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wken_ff <= PCB_REG_RESET;
      wked_ff <= PCB_REG_RESET;
    end else if (on_b) begin
      if (hit_wken) begin
        wken_ff <= move_i.wdata;
      end
      if (hit_wked) begin
        wked_ff <= move_i.wdata;
      end
    end
  end

  // edge detection on the Port B pin levels
  pcb_wake_edge #(
    .WIDTH        (8)
  ) u_wake_edge (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .pin_i        (port_b_pins),
    .enable_low_i (wken_ff),
    .falling_i    (wked_ff),
    .edge_o       (wake_edges)
  );

  // ****************************************************************
  // pending flags
  // ****************************************************************
  // exchange loads the written value, then new edges are ORed on top
  always_comb begin
    nxt_pend = pend_xch ? move_i.wdata : pend_ff;
    nxt_pend = nxt_pend | wake_edges;
  end

  // pending flags and the one-cycle event pulse
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pend_ff     <= PCB_REG_RESET;
      wake_evt_ff <= 1'b0;
    end else begin
      pend_ff     <= nxt_pend;
      wake_evt_ff <= |wake_edges;
    end
  end

  // ****************************************************************
  // comparator
  // ****************************************************************
  // result sampled only while enabled; bit 0 of the register is this flag
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmp_ctl_ff <= PCB_REG_RESET;
      cmp_res_ff <= 1'b0;
    end else begin
      if (cmp_xch) begin
        cmp_ctl_ff <= move_i.wdata;
      end
      if (!cmp_ctl_ff[PCB_CMP_DIS_BIT]) begin
        cmp_res_ff <= cmp_above_i;
      end else begin
        cmp_res_ff <= 1'b0;
      end
    end
  end

  // enable kept in its own flop so the output leaves a register directly
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmp_en_ff <= 1'b0;
    end else if (cmp_xch) begin
      cmp_en_ff <= !move_i.wdata[PCB_CMP_DIS_BIT];
    end
  end

  // result routed to the first Port B pin when bits 6 and 7 are clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmp_out_ff <= '0;
      cmp_oe_ff  <= '0;
    end else begin
      cmp_out_ff <= '0;
      cmp_oe_ff  <= '0;
      cmp_out_ff[PCB_CMP_OUT_PIN] <= cmp_res_ff;
      cmp_oe_ff[PCB_CMP_OUT_PIN]  <= !cmp_ctl_ff[PCB_CMP_OE_N_BIT] &&
                                     !cmp_ctl_ff[PCB_CMP_DIS_BIT];
    end
  end

  // ****************************************************************
  // read data back to the working register
  // ****************************************************************
  // write modes other than the exchanges return zero; nothing to read
  always_comb begin
    nxt_rdata = '0;
    if (pend_xch) begin
      nxt_rdata = pend_ff;
    end else if (cmp_xch) begin
      nxt_rdata = {cmp_ctl_ff[7:1], cmp_res_ff};
    end else if (port_ok && !is_wr) begin
      case (mode_ff)
        PCB_MODE_DIR_RD:  nxt_rdata = dir_ff[move_i.port];
        PCB_MODE_PULL_RD: nxt_rdata = pull_ff[move_i.port];
        PCB_MODE_LVL_RD:  nxt_rdata = lvl_ff[move_i.port];
        PCB_MODE_ST_RD:   nxt_rdata = (move_i.port == PCB_PORT_A) ? 8'h00
                                                                  : st_ff[move_i.port];
        default:          nxt_rdata = '0;
      endcase
    end
  end

  // answer and its valid pulse, one cycle after the move
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= move_i.valid;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign mode_o         = mode_ff;
  assign move_rdata_o   = rdata_ff;
  assign move_rvalid_o  = rvalid_ff;
  assign pincfg_o       = pincfg_ff;
  assign cmp_pin_out_o  = cmp_out_ff;
  assign cmp_pin_oe_o   = cmp_oe_ff;
  assign wake_pending_o = pend_ff;
  assign wake_event_o   = wake_evt_ff;
  assign cmp_enable_o   = cmp_en_ff;

endmodule // pcb_port_cfg

// ==== hdl/pcb_wake_edge.sv ====
`timescale 1ns/1ns
// edge detector for the wakeup pins, one lane per bit
module pcb_wake_edge
  import pcb_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // pin levels and settings
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] enable_low_i,
  input  wire logic [WIDTH-1:0] falling_i,
  // detected valid edges
  output logic      [WIDTH-1:0] edge_o
);

  // elaboration check: at least one lane
  if (WIDTH < 1) begin : g_bad_width
    $error("pcb_wake_edge: WIDTH must be at least one");
  end

  logic [WIDTH-1:0] prev_ff;

  // last level; reset to high so the pin default does not look like an edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prev_ff <= '1;
    end else begin
      prev_ff <= pin_i;
    end
  end

  // per bit: enabled pin, selected direction
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      assign edge_o[g] = !enable_low_i[g] &&
                         (falling_i[g] ? (prev_ff[g] && !pin_i[g])
                                       : (!prev_ff[g] && pin_i[g]));
    end
  endgenerate

endmodule // pcb_wake_edge

// ==== test/pcb_pin_model.sv ====
`timescale 1ns/1ns
// ********
// outside circuits on the pins
// ********
module pcb_pin_model
  import pcb_pkg::*;
(
  // clock and wanted levels
  input  wire logic                 core_clk_i,
  input  wire logic [39:0]          ext_level_i,
  input  wire pcb_pincfg_type [4:0] pincfg_i,
  // levels seen by the bank
  output logic      [39:0]          pin_level_o,
  output logic                      cmp_above_o
);
  logic [39:0] float_ff;

  // an unpulled output pin wanders so no stale level is trusted
  initial float_ff = 40'h55_5555_5555;
  always @(posedge core_clk_i) begin
    float_ff <= ~float_ff;
  end

  // inputs follow the outside; port data is not modelled
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (pincfg_i[i / 8].dir_in[i % 8])
        pin_level_o[i] = ext_level_i[i];
      else
        pin_level_o[i] = float_ff[i] | ~pincfg_i[i / 8].pull_dis[i % 8];
    end
  end

  // analog compare reduced to levels: positive high, negative low
  assign cmp_above_o = pin_level_o[10] & ~pin_level_o[9];
endmodule // pcb_pin_model

// ==== test/pcb_port_cfg_chk.sv ====
`timescale 1ns/1ns
// ********
// port bank checker
// ********
module pcb_port_cfg_chk
  import pcb_pkg::*;
#(
  parameter int NPORT = PCB_NPORT
) (
  // clock and reset
  input wire logic                       core_clk_i,
  input wire logic                       rst_n_i,
  // core side
  input wire logic                       mode_wr_i,
  input wire logic [4:0]                 mode_wdata_i,
  input wire logic [4:0]                 mode_o,
  input wire pcb_move_type               move_i,
  input wire logic [7:0]                 move_rdata_o,
  input wire logic                       move_rvalid_o,
  // status side
  input wire pcb_pincfg_type [NPORT-1:0] pincfg_o,
  input wire logic [7:0]                 wake_pending_o,
  input wire logic                       wake_event_o,
  input wire logic                       cmp_enable_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // reset itself is the cause here, so it cannot disable
  reset_values_a: assert property (
    disable iff (1'b0) !rst_n_i |=> mode_o == PCB_MODE_RESET && &pincfg_o)
    else $error("reset values wrong");
  mode_take_a: assert property (
    mode_wr_i |=> mode_o == $past(mode_wdata_i))
    else $error("mode write lost");
  mode_hold_a: assert property (
    !mode_wr_i |=> $stable(mode_o))
    else $error("mode changed unasked");
  move_answer_a: assert property (
    move_i.valid |=> move_rvalid_o ##1 (move_rvalid_o == $past(move_i.valid)))
    else $error("move answer missing");
  pend_swap_a: assert property (
    move_i.valid && move_i.port == PCB_PORT_B && mode_o == PCB_MODE_PEND_XCH
    |=> move_rdata_o == $past(wake_pending_o)
        && ((wake_pending_o & ~$past(move_i.wdata)) == 8'h00 || wake_event_o))
    else $error("pending swap wrong");
  dir_write_a: assert property (
    move_i.valid && move_i.port < 3'h5 && mode_o == PCB_MODE_DIR_WR
    |=> ##1 pincfg_o[$past(move_i.port, 2)].dir_in == $past(move_i.wdata, 2))
    else $error("direction write lost");
  port_a_schmitt_a: assert property (
    pincfg_o[0].schmitt_dis == 8'hFF)
    else $error("port a schmitt changed");
  wake_flag_a: assert property (
    wake_event_o |-> wake_pending_o != 8'h00)
    else $error("event without pending bit");
  cmp_enable_a: assert property (
    move_i.valid && move_i.port == PCB_PORT_B && mode_o == PCB_MODE_CMP_XCH
    |=> cmp_enable_o == !$past(move_i.wdata[7]))
    else $error("comparator enable wrong");
endmodule // pcb_port_cfg_chk

bind pcb_port_cfg pcb_port_cfg_chk #(.NPORT(NPORT)) i_pcb_port_cfg_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mode_wr_i(mode_wr_i),
  .mode_wdata_i(mode_wdata_i), .mode_o(mode_o), .move_i(move_i),
  .move_rdata_o(move_rdata_o), .move_rvalid_o(move_rvalid_o),
  .pincfg_o(pincfg_o), .wake_pending_o(wake_pending_o),
  .wake_event_o(wake_event_o), .cmp_enable_o(cmp_enable_o)
);

// ==== test/testbench.sv ====
`timescale 1ns/1ns
// ********
// port bank testbench
// ********
module testbench
  import pcb_pkg::*;
;
  logic                 core_clk_i = 1'b0;
  logic                 rst_n_i;
  logic                 mode_wr_i;
  logic [4:0]           mode_wdata_i;
  logic [4:0]           mode_o;
  pcb_move_type         move_i;
  logic [7:0]           move_rdata_o;
  logic                 move_rvalid_o;
  logic [39:0]          pin_level_i;
  logic                 cmp_above_i;
  pcb_pincfg_type [4:0] pincfg_o;
  logic [7:0]           cmp_pin_out_o;
  logic [7:0]           cmp_pin_oe_o;
  logic [7:0]           wake_pending_o;
  logic                 wake_event_o;
  logic                 cmp_enable_o;
  logic [39:0]          ext_level;
  logic [7:0]           rd;
  int                   err_total;
  int                   checks_done;

  always #2 core_clk_i = ~core_clk_i;

  pcb_port_cfg i_pcb_port_cfg (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mode_wr_i(mode_wr_i),
    .mode_wdata_i(mode_wdata_i), .mode_o(mode_o), .move_i(move_i),
    .move_rdata_o(move_rdata_o), .move_rvalid_o(move_rvalid_o),
    .pin_level_i(pin_level_i), .cmp_above_i(cmp_above_i), .pincfg_o(pincfg_o),
    .cmp_pin_out_o(cmp_pin_out_o), .cmp_pin_oe_o(cmp_pin_oe_o),
    .wake_pending_o(wake_pending_o), .wake_event_o(wake_event_o),
    .cmp_enable_o(cmp_enable_o)
  );

  pcb_pin_model i_pcb_pin_model (
    .core_clk_i(core_clk_i), .ext_level_i(ext_level), .pincfg_i(pincfg_o),
    .pin_level_o(pin_level_i), .cmp_above_o(cmp_above_i)
  );

  // ********
  // helpers
  // ********
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic set_mode(input logic [4:0] m);
    @(negedge core_clk_i);
    mode_wr_i = 1'b1;
    mode_wdata_i = m;
    @(negedge core_clk_i);
    mode_wr_i = 1'b0;
    chk("mode", m, mode_o);
  endtask

  // the answer pulse lasts one cycle, so it is looked at once
  task automatic move(input logic [2:0] p, input logic [7:0] w, output logic [7:0] r);
    @(negedge core_clk_i);
    move_i = '{1'b1, p, w};
    @(negedge core_clk_i);
    move_i.valid = 1'b0;
    chk("rvalid", 1'b1, move_rvalid_o);
    r = move_rdata_o;
  endtask

  function automatic logic [7:0] wval(int k, int p);
    return 8'hA5 ^ 8'(k * 16 + p);
  endfunction

  task automatic chk_home;
    chk("mode", PCB_MODE_RESET, mode_o);
    chk("pending", 8'hFF, wake_pending_o);
    for (int p = 0; p < 5; p++)
      chk("cfg", 32'hFFFF_FFFF, pincfg_o[p]);
  endtask

  // ********
  // scenarios
  // ********
  initial begin
    rst_n_i = 1'b0;
    mode_wr_i = 1'b0;
    mode_wdata_i = 5'h00;
    move_i = '0;
    ext_level = '1;
    err_total = 0;
    checks_done = 0;
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk_home;
    // first pass leans on the power-up mode, no selector write
    for (int k = 0; k < 4; k++) begin
      if (k > 0)
        set_mode(PCB_MODE_DIR_WR - 5'(k));
      for (int p = 0; p < 5; p++) begin
        move(3'(p), wval(k, p), rd);
        @(negedge core_clk_i);
        chk("field", (k == 3 && p == 0) ? 8'hFF : wval(k, p),
            pincfg_o[p][31 - 8 * k -: 8]);
      end
      set_mode(PCB_MODE_DIR_RD - 5'(k));
      for (int p = 0; p < 5; p++) begin
        move(3'(p), 8'h00, rd);
        chk("readback", (k == 3 && p == 0) ? 8'h00 : wval(k, p), rd);
      end
    end
    move(3'h5, 8'h00, rd);
    chk("bad port", 8'h00, rd);
    set_mode(PCB_MODE_DIR_WR);
    move(PCB_PORT_B, 8'hFF, rd);
    // wake on pins 2..5; 2,3 falling, 4,5 rising
    set_mode(PCB_MODE_WKEN_WR);
    move(PCB_PORT_B, 8'hC3, rd);
    set_mode(PCB_MODE_WKED_WR);
    move(PCB_PORT_B, 8'h0F, rd);
    set_mode(PCB_MODE_PEND_XCH);
    move(PCB_PORT_B, 8'h00, rd);
    chk("pend swap", 8'hFF, rd);
    ext_level[15:8] = 8'h00;
    @(negedge core_clk_i);
    chk("wake event", 1'b1, wake_event_o);
    repeat (2) @(negedge core_clk_i);
    chk("pending", 8'h0C, wake_pending_o);
    move(PCB_PORT_B, 8'h00, rd);
    chk("pend swap", 8'h0C, rd);
    ext_level[15:8] = 8'hFF;
    repeat (3) @(negedge core_clk_i);
    move(PCB_PORT_B, 8'h01, rd);
    chk("pend swap", 8'h30, rd);
    chk("pending", 8'h01, wake_pending_o);
    // comparator: disabled at reset, then driving the first pin
    set_mode(PCB_MODE_CMP_XCH);
    move(PCB_PORT_B, 8'h00, rd);
    chk("cmp swap", 8'hFE, rd);
    ext_level[15:8] = 8'h04;
    repeat (4) @(negedge core_clk_i);
    chk("cmp enable", 1'b1, cmp_enable_o);
    chk("cmp oe", 1'b1, cmp_pin_oe_o[0]);
    chk("cmp out", 1'b1, cmp_pin_out_o[0]);
    move(PCB_PORT_B, 8'h40, rd);
    chk("cmp swap", 8'h01, rd);
    ext_level[15:8] = 8'h02;
    repeat (4) @(negedge core_clk_i);
    chk("cmp oe", 1'b0, cmp_pin_oe_o[0]);
    move(PCB_PORT_B, 8'h80, rd);
    chk("cmp swap", 8'h40, rd);
    repeat (2) @(negedge core_clk_i);
    chk("cmp enable", 1'b0, cmp_enable_o);
    // lower table half: exchanges and wake writes on port B
    set_mode(PCB_MODE_CMP_LO);
    move(PCB_PORT_B, 8'hFF, rd);
    chk("cmp swap", 8'h80, rd);
    set_mode(PCB_MODE_WKEN_LO);
    move(PCB_PORT_B, 8'hFD, rd);
    set_mode(PCB_MODE_WKED_LO);
    move(PCB_PORT_B, 8'h00, rd);
    set_mode(PCB_MODE_PEND_LO);
    move(PCB_PORT_B, 8'h00, rd);
    chk("pend swap", 8'h0D, rd);
    ext_level[15:8] = 8'h00;
    repeat (3) @(negedge core_clk_i);
    chk("pending", 8'h00, wake_pending_o);
    ext_level[15:8] = 8'h02;
    repeat (3) @(negedge core_clk_i);
    chk("pending", 8'h02, wake_pending_o);
    // second reset after everything was changed
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk_home;
    summarize;
  end

  // a hung run still ends with a verdict
  initial begin
    #100000;
    err_total++;
    summarize;
  end
endmodule // testbench
